// ### design/adc_ctl_regs.svh
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// register addresses (7-bit serial address space)
`define REG_POWER 7'h00
`define REG_FORMAT 7'h01
`define REG_DRVPWR 7'h02
`define REG_TIMING 7'h03
`define REG_IMP_A 7'h04
`define REG_IMP_B 7'h05
`define REG_DIVFMT 7'h06
`define REG_RSVD 7'h07
`define REG_CMODE 7'h08
`define REG_SWRESET 7'h0A

// reset values
`define RST_POWER 8'h03
`define RST_FORMAT 8'h00
`define RST_DRVPWR 8'h00
`define RST_TIMING 8'h6D
`define RST_IMP 8'h00
`define RST_DIVFMT 8'h00
`define RST_CMODE 8'h00
`define SWRESET_KEY 8'h5A
// status byte: fixed reserved bit 2 set, the loader is always done here
`define STATUS_BYTE 8'h14

// field positions
`define FMT_ORDER_B 4
`define FMT_ORDER_A 3
`define FMT_INTERLEAVE_BUS_SELECT 2
`define FMT_MUX 1
`define DRV_PD_HI 3
`define DRV_PD_LO 2
`define DRV_DOR_OFF 1
`define DRV_OUTPUT_DATA_CLOCK_OFF 0
`define TIM_SKIP 7
`define TIM_HALF 6
`define DIV_PATSEL 7
`define DIV_TEST 6
`define DIV_SYNC 2

// serial frame
`define FRAME_BITS 5'd16
`define HDR_BITS 5'd8
`define RAMP_MAX 10'h3FF
`define PAT_A 10'h155
`define PAT_B 10'h2AA
`define TWOC_FLIP 10'h200

`endif

// ### design/adc_ctl_pkg.sv
package adc_ctl_pkg;
	typedef enum logic [1:0] {FMT_TWOS, FMT_OFFSET, FMT_GRAY, FMT_TWOS2} num_fmt_t;
	typedef enum logic [1:0] {CH_OFF, CH_STANDBY, CH_ACTIVE} ch_state_t;
	typedef struct packed {
		logic [9:0] data;
		logic over;
	} sample_t;
	typedef struct packed {
		logic [9:0] data_a;
		logic [9:0] data_b;
		logic [9:0] data_a_oe;
		logic [9:0] data_b_oe;
		logic over;
		logic over_oe;
	} out_bus_t;
endpackage

// ### design/adc_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer: a stall on the output side never drops a word
module adc_skid_buf (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire adc_ctl_pkg::sample_t [1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output adc_ctl_pkg::sample_t [1:0] out_data_o
);
	import adc_ctl_pkg::*;
	sample_t [1:0] mem_q [2];
	logic wr_q, rd_q;
	logic [1:0] cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = cnt_q != 2'd2;
	assign out_valid_o = cnt_q != 2'd0;
	assign out_data_o = mem_q[rd_q];
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'd0;
		end else if (flush_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge clk_i) begin
		if (push) mem_q[wr_q] <= in_data_i;
	end
endmodule
`default_nettype wire

// ### design/adc_ctl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_regs.svh"
// Operation
// - shutdown pin picks one of two power sets
// - high nibble for pin high, low nibble low
// - single channel on puts other off or in standby
// - standby bit turns off channels into standby
// - adder with any channel on averages both
// - adder: both channel bits zero to sleep
// - average goes out on both buses, only on the selected bus when interleaved
// - order bits reverse each channel's pins, B's for both when interleaved on B
// - format bit 1 picks dual or interleaved
// - bus select picks bus and first channel
// - powered down outputs: z, low, high
// - driver-off bits tristate over-range and clock
// - timing bit 7 skips aligner delay
// - half period delay, not when interleaved
// - three-bit clock and data delay codes
// - test mode ramp or alternating pattern
// - numeric format two's, offset, gray
// - divider field: none, two, four
// - sync mode bit: slip or edge
// - impedance codes 50 to 300 ohms
// - writing 5Ah to 0Ah restores defaults
// - 16-bit frame, rw, address, data
module adc_ctl_top (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic power_select_pin_i,
	input wire logic sync_i,
	input wire logic ser_cs_b_i,
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	output logic ser_data_o,
	output logic ser_data_oe_o,
	input wire adc_ctl_pkg::sample_t conv_a_i,
	input wire adc_ctl_pkg::sample_t conv_b_i,
	output logic in_ready_o,
	input wire logic out_ready_i,
	output logic out_valid_o,
	output adc_ctl_pkg::out_bus_t out_bus_o,
	output logic output_data_clock_o,
	output logic output_data_clock_oe_o,
	output adc_ctl_pkg::ch_state_t chan_a_state_o,
	output adc_ctl_pkg::ch_state_t chan_b_state_o,
	output logic sample_en_o,
	output logic aligner_skip_o,
	output logic half_delay_active_o,
	output logic [3:0] out_clock_delay_steps_o,
	output logic [3:0] data_delay_steps_o,
	output logic [8:0] chan_a_clock_ohms_o,
	output logic [8:0] chan_a_data_ohms_o,
	output logic [8:0] chan_b_clock_ohms_o,
	output logic [8:0] chan_b_data_ohms_o,
	output logic clock_term_on_o,
	output logic [7:0] input_common_level_o
);
	import adc_ctl_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [9:0] reverse10(input logic [9:0] v);
		logic [9:0] r;
		r = 10'h000;
		for (int i = 0; i < 10; i++) r[i] = v[9 - i];
		return r;
	endfunction

	// signed steps of T/16, code 100 treated as nominal
	function automatic logic [3:0] delay_steps(input logic [2:0] c);
		logic [3:0] s;
		s = 4'h0;
		if (!c[2]) s = {1'b0, c};
		else if (c[1:0] != 2'b00) s = 4'h0 - {2'b00, c[1:0]};
		return s;
	endfunction

	function automatic logic [8:0] ohms(input logic [2:0] c);
		logic [8:0] o;
		o = 9'd300;
		if (!c[2]) begin
			case (c[1:0])
				2'b00: o = 9'd50;
				2'b01: o = 9'd75;
				2'b10: o = 9'd100;
				default: o = 9'd150;
			endcase
		end
		return o;
	endfunction

	// offset-binary in, chosen coding out
	function automatic logic [9:0] encode(input logic [9:0] ob, input num_fmt_t f);
		logic [9:0] r;
		r = ob ^ `TWOC_FLIP;
		if (f == FMT_OFFSET) r = ob;
		else if (f == FMT_GRAY) r = ob ^ (ob >> 1);
		return r;
	endfunction

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_b;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) rst_sync_q <= 2'b00;
		else rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_b = rst_sync_q[1];

	logic [4:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 5'b00100;
			pin_s2_q <= 5'b00100;
		end else begin
			pin_s1_q <= {power_select_pin_i, sync_i, ser_cs_b_i, ser_clk_i, ser_data_i};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire pwr_sel = pin_s2_q[4];
	wire sync_s = pin_s2_q[3];
	wire cs_b_s = pin_s2_q[2];
	wire sck_s = pin_s2_q[1];
	wire sdi_s = pin_s2_q[0];

	// ----------------------------------------
	// serial port
	// ----------------------------------------
	logic sck_q;
	logic [4:0] bit_cnt_q;
	logic [15:0] shift_q;
	logic [7:0] rd_shift_q;
	logic rd_drive_q;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) sck_q <= 1'b0;
		else sck_q <= sck_s;
	end
	wire sck_rise = sck_s && !sck_q && !cs_b_s;
	wire sck_fall = !sck_s && sck_q && !cs_b_s;
	wire [15:0] shift_nx = {shift_q[14:0], sdi_s};
	wire frame_done = sck_rise && (bit_cnt_q == `FRAME_BITS - 5'd1);
	wire hdr_done = sck_rise && (bit_cnt_q == `HDR_BITS - 5'd1);
	wire is_write = frame_done && !shift_nx[15];
	wire [6:0] wr_addr = shift_nx[14:8];
	wire [7:0] wr_data = shift_nx[7:0];
	wire sw_reset = is_write && wr_addr == `REG_SWRESET && wr_data == `SWRESET_KEY;
	wire rd_hit = hdr_done && shift_nx[7];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] power_state_config_q, output_bus_format_q, output_driver_power_q;
	logic [7:0] output_timing_adjust_q, chan_a_output_impedance_q, chan_b_output_impedance_q;
	logic [7:0] divider_format_pattern_q, input_common_level_q;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			power_state_config_q <= `RST_POWER;
			output_bus_format_q <= `RST_FORMAT;
			output_driver_power_q <= `RST_DRVPWR;
			output_timing_adjust_q <= `RST_TIMING;
			chan_a_output_impedance_q <= `RST_IMP;
			chan_b_output_impedance_q <= `RST_IMP;
			divider_format_pattern_q <= `RST_DIVFMT;
			input_common_level_q <= `RST_CMODE;
		end else if (sw_reset) begin
			power_state_config_q <= `RST_POWER;
			output_bus_format_q <= `RST_FORMAT;
			output_driver_power_q <= `RST_DRVPWR;
			output_timing_adjust_q <= `RST_TIMING;
			chan_a_output_impedance_q <= `RST_IMP;
			chan_b_output_impedance_q <= `RST_IMP;
			divider_format_pattern_q <= `RST_DIVFMT;
			input_common_level_q <= `RST_CMODE;
		end else if (is_write) begin
			case (wr_addr)
				`REG_POWER: power_state_config_q <= wr_data;
				`REG_FORMAT: output_bus_format_q <= wr_data;
				`REG_DRVPWR: output_driver_power_q <= wr_data;
				`REG_TIMING: output_timing_adjust_q <= wr_data;
				`REG_IMP_A: chan_a_output_impedance_q <= wr_data;
				`REG_IMP_B: chan_b_output_impedance_q <= wr_data;
				`REG_DIVFMT: divider_format_pattern_q <= wr_data;
				`REG_CMODE: input_common_level_q <= wr_data;
				default: ;
			endcase
		end
	end

	logic [7:0] rd_val;
	always_comb begin
		case (shift_nx[6:0])
			`REG_POWER: rd_val = power_state_config_q;
			`REG_FORMAT: rd_val = output_bus_format_q;
			`REG_DRVPWR: rd_val = output_driver_power_q;
			`REG_TIMING: rd_val = output_timing_adjust_q;
			`REG_IMP_A: rd_val = chan_a_output_impedance_q;
			`REG_IMP_B: rd_val = chan_b_output_impedance_q;
			`REG_DIVFMT: rd_val = divider_format_pattern_q;
			`REG_CMODE: rd_val = input_common_level_q;
			`REG_SWRESET: rd_val = `STATUS_BYTE;
			default: rd_val = 8'h00;
		endcase
	end

	// read data leaves msb first on each falling serial clock after the header
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt_q <= 5'd0;
			shift_q <= 16'h0000;
			rd_shift_q <= 8'h00;
			rd_drive_q <= 1'b0;
			ser_data_o <= 1'b0;
		end else if (cs_b_s) begin
			bit_cnt_q <= 5'd0;
			rd_drive_q <= 1'b0;
		end else begin
			if (sck_rise) begin
				shift_q <= shift_nx;
				bit_cnt_q <= bit_cnt_q + 5'd1;
			end
			if (rd_hit) begin
				rd_shift_q <= rd_val;
				rd_drive_q <= 1'b1;
			end else if (sck_fall && rd_drive_q) begin
				ser_data_o <= rd_shift_q[7];
				rd_shift_q <= {rd_shift_q[6:0], 1'b0};
			end
			if (frame_done) rd_drive_q <= 1'b0;
		end
	end
	assign ser_data_oe_o = rd_drive_q && !cs_b_s;

	// ----------------------------------------
	// power state decode
	// ----------------------------------------
	wire [3:0] pset = pwr_sel ? power_state_config_q[7:4] : power_state_config_q[3:0];
	wire adder = pset[3];
	wire stby = pset[2];
	wire b_on = pset[1];
	wire a_on = pset[0];
	wire any_on = a_on || b_on;
	wire avg_mode = adder && any_on;
	ch_state_t idle_st;
	assign idle_st = stby ? CH_STANDBY : CH_OFF;
	assign chan_a_state_o = (a_on || avg_mode) ? CH_ACTIVE : idle_st;
	assign chan_b_state_o = (b_on || avg_mode) ? CH_ACTIVE : idle_st;
	// standby and full power-down both stop the data path
	wire all_down = !any_on;
	wire a_live = chan_a_state_o == CH_ACTIVE;
	wire b_live = chan_b_state_o == CH_ACTIVE;

	// ----------------------------------------
	// clock divider with sync
	// ----------------------------------------
	logic [1:0] div_q;
	logic [2:0] sync_dly_q;
	logic sync_q;
	wire [1:0] div_sel = divider_format_pattern_q[1:0];
	wire [1:0] div_mask = (div_sel == 2'b01) ? 2'b01 : (div_sel == 2'b10) ? 2'b11 : 2'b00;
	wire sync_hit = sync_dly_q[2];
	wire edge_mode = divider_format_pattern_q[`DIV_SYNC];
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 2'b00;
			sync_q <= 1'b0;
			sync_dly_q <= 3'b000;
		end else begin
			sync_q <= sync_s;
			sync_dly_q <= {sync_dly_q[1:0], sync_s && !sync_q};
			if (sync_hit && edge_mode) div_q <= 2'b00;
			else if (sync_hit) div_q <= div_q;
			else div_q <= (div_q + 2'b01) & div_mask;
		end
	end
	assign sample_en_o = (div_q == 2'b00) && !(sync_hit && !edge_mode);

	// ----------------------------------------
	// sample path
	// ----------------------------------------
	logic [9:0] ramp_q;
	logic alt_q;
	wire test_on = divider_format_pattern_q[`DIV_TEST];
	wire pat_sel = divider_format_pattern_q[`DIV_PATSEL];
	num_fmt_t fmt;
	assign fmt = num_fmt_t'(divider_format_pattern_q[5:4]);
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ramp_q <= 10'h000;
			alt_q <= 1'b0;
		end else if (sample_en_o && in_ready_o) begin
			ramp_q <= (ramp_q == `RAMP_MAX) ? 10'h000 : ramp_q + 10'h001;
			alt_q <= ~alt_q;
		end
	end
	wire [10:0] sum_ab = {1'b0, conv_a_i.data} + {1'b0, conv_b_i.data};
	wire [9:0] avg_ob = sum_ab[10:1];
	sample_t raw_a, raw_b, src_a, src_b;
	assign raw_a.data = avg_mode ? avg_ob : conv_a_i.data;
	assign raw_a.over = avg_mode ? (conv_a_i.over | conv_b_i.over) : conv_a_i.over;
	assign raw_b = avg_mode ? raw_a : conv_b_i;
	wire [9:0] pat = alt_q ? `PAT_B : `PAT_A;
	assign src_a.data = encode(test_on ? (pat_sel ? pat : ramp_q) : raw_a.data, fmt);
	assign src_a.over = test_on ? (pat_sel && !alt_q) : raw_a.over;
	assign src_b.data = encode(test_on ? (pat_sel ? pat : ramp_q) : raw_b.data, fmt);
	assign src_b.over = test_on ? (pat_sel && !alt_q) : raw_b.over;

	sample_t [1:0] buf_out;
	logic buf_rd_ok;
	adc_skid_buf u_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b),
		.flush_i(sw_reset),
		.in_valid_i(sample_en_o && !all_down),
		.in_ready_o(in_ready_o),
		.in_data_i({src_a, src_b}),
		.out_valid_o(out_valid_o),
		.out_ready_i(buf_rd_ok),
		.out_data_o(buf_out)
	);

	// ----------------------------------------
	// output formatting
	// ----------------------------------------
	wire mux_mode = output_bus_format_q[`FMT_MUX];
	wire mux_on_b = output_bus_format_q[`FMT_INTERLEAVE_BUS_SELECT];
	wire rev_a = output_bus_format_q[`FMT_ORDER_A];
	wire rev_b = output_bus_format_q[`FMT_ORDER_B];
	wire [1:0] pd_lvl = {output_driver_power_q[`DRV_PD_HI], output_driver_power_q[`DRV_PD_LO]};
	wire pd_drive = pd_lvl[0];
	wire [9:0] pd_word = pd_lvl[1] ? 10'h3FF : 10'h000;
	logic phase_q; // interleave: 0 = first channel slot
	wire pop = out_valid_o && out_ready_i;
	wire take = pop && (!mux_mode || phase_q);
	// interleaved: the pair stays in the buffer until its second slot is sent
	assign buf_rd_ok = out_ready_i && (!mux_mode || phase_q);
	out_bus_t bus_q;
	wire [9:0] sa = buf_out[1].data;
	wire [9:0] sb = buf_out[0].data;
	wire [9:0] a_word = rev_a ? reverse10(sa) : sa;
	wire [9:0] b_word = rev_b ? reverse10(sb) : sb;
	wire first_b = mux_on_b;
	wire [9:0] mux_word = (phase_q ^ first_b) ? (mux_on_b ? reverse10(sb) ^ (rev_b ? 10'h000 : reverse10(sb) ^ sb) : b_word)
		: (mux_on_b ? (rev_b ? reverse10(sa) : sa) : a_word);
	wire mux_over = (phase_q ^ first_b) ? buf_out[0].over : buf_out[1].over;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= 1'b0;
			bus_q <= '0;
		end else begin
			if (!mux_mode || sw_reset) phase_q <= 1'b0;
			else if (pop) phase_q <= ~phase_q;
			if (pop && !mux_mode) begin
				bus_q.data_a <= a_live ? a_word : pd_word;
				bus_q.data_b <= b_live ? b_word : pd_word;
				bus_q.data_a_oe <= {10{a_live || pd_drive}};
				bus_q.data_b_oe <= {10{b_live || pd_drive}};
				bus_q.over <= buf_out[1].over | (buf_out[0].over & !a_live);
			end else if (pop) begin
				bus_q.data_a <= mux_on_b ? pd_word : mux_word;
				bus_q.data_b <= mux_on_b ? mux_word : pd_word;
				bus_q.data_a_oe <= {10{!mux_on_b || pd_drive}};
				bus_q.data_b_oe <= {10{mux_on_b || pd_drive}};
				bus_q.over <= mux_over;
			end else if (all_down) begin
				bus_q.data_a <= pd_word;
				bus_q.data_b <= pd_word;
				bus_q.data_a_oe <= {10{pd_drive}};
				bus_q.data_b_oe <= {10{pd_drive}};
			end
			bus_q.over_oe <= !output_driver_power_q[`DRV_DOR_OFF] && !all_down;
		end
	end
	assign out_bus_o = bus_q;
	logic output_data_clock_q;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) output_data_clock_q <= 1'b0;
		else output_data_clock_q <= pop && !take ? 1'b1 : take;
	end
	assign output_data_clock_o = output_data_clock_q;
	assign output_data_clock_oe_o = !output_driver_power_q[`DRV_OUTPUT_DATA_CLOCK_OFF];

	// ----------------------------------------
	// analog-facing controls
	// ----------------------------------------
	assign aligner_skip_o = output_timing_adjust_q[`TIM_SKIP];
	assign half_delay_active_o = output_timing_adjust_q[`TIM_HALF] && !mux_mode;
	assign out_clock_delay_steps_o = delay_steps(output_timing_adjust_q[5:3]);
	assign data_delay_steps_o = delay_steps(output_timing_adjust_q[2:0]);
	assign chan_a_clock_ohms_o = ohms(chan_a_output_impedance_q[5:3]);
	assign chan_a_data_ohms_o = ohms(chan_a_output_impedance_q[2:0]);
	assign chan_b_clock_ohms_o = ohms(chan_b_output_impedance_q[5:3]);
	assign chan_b_data_ohms_o = ohms(chan_b_output_impedance_q[2:0]);
	assign clock_term_on_o = divider_format_pattern_q[3];
	assign input_common_level_o = input_common_level_q;
endmodule
`default_nettype wire

// ### tb/adc_ctl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_checker (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ser_cs_b_i,
	input wire logic ser_data_oe_o,
	input wire logic out_ready_i,
	input wire logic out_valid_o,
	input wire adc_ctl_pkg::out_bus_t out_bus_o,
	input wire adc_ctl_pkg::ch_state_t chan_a_state_o,
	input wire adc_ctl_pkg::ch_state_t chan_b_state_o,
	input wire logic [3:0] data_delay_steps_o,
	input wire logic [3:0] out_clock_delay_steps_o,
	input wire logic [8:0] chan_a_data_ohms_o,
	input wire logic [8:0] chan_b_clock_ohms_o
);
	import adc_ctl_pkg::*;
	// ----------------------------------------
	// port relations
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence cs_idle;
		ser_cs_b_i [*6];
	endsequence
	sequence held_empty;
		!out_valid_o [*2];
	endsequence
	a_ser_release: assert property (cs_idle |-> !ser_data_oe_o)
		else $error("read driver on while deselected");
	a_buf_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o)
		else $error("word lost during stall");
	a_no_mixed_sleep: assert property (!(chan_a_state_o == CH_OFF && chan_b_state_o == CH_STANDBY) &&
		!(chan_a_state_o == CH_STANDBY && chan_b_state_o == CH_OFF))
		else $error("standby mixed with full power down");
	a_delay_range: assert property ($signed(data_delay_steps_o) >= -4'sh3 &&
		$signed(out_clock_delay_steps_o) <= 4'sh3)
		else $error("delay step outside three steps");
	a_ohms_legal: assert property (chan_a_data_ohms_o inside {9'h032, 9'h04B, 9'h064, 9'h096,
		9'h12C} && chan_b_clock_ohms_o != 9'h000)
		else $error("impedance value not in set");
	a_pd_uniform: assert property (out_bus_o.data_a_oe inside {10'h000, 10'h3FF})
		else $error("bus a drivers split");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |-> !out_valid_o && !ser_data_oe_o)
		else $error("outputs active in reset");
	a_release_quiet: assert property (disable iff (1'b0) $rose(rst_b_i) |-> held_empty)
		else $error("data before reset release settled");
endmodule
bind adc_ctl_top adc_ctl_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.ser_cs_b_i(ser_cs_b_i), .ser_data_oe_o(ser_data_oe_o), .out_ready_i(out_ready_i),
	.out_valid_o(out_valid_o), .out_bus_o(out_bus_o), .chan_a_state_o(chan_a_state_o),
	.chan_b_state_o(chan_b_state_o), .data_delay_steps_o(data_delay_steps_o),
	.out_clock_delay_steps_o(out_clock_delay_steps_o), .chan_a_data_ohms_o(chan_a_data_ohms_o),
	.chan_b_clock_ohms_o(chan_b_clock_ohms_o));
`default_nettype wire

// ### tb/adc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	input wire logic clk_i,
	input wire logic line_i,
	output logic cs_b_o,
	output logic sclk_o,
	output logic sdo_o
);
	// ----------------------------------------
	// serial host, four clocks per phase
	// ----------------------------------------
	initial begin
		cs_b_o = 1'b1;
		sclk_o = 1'b0;
		sdo_o = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [15:0] f;
		f = {rw, a, wd};
		rd = 8'h00;
		half();
		cs_b_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			// released line shows a changing value, never the last bit
			sdo_o = (i < 8 && rw) ? ~sdo_o : f[i];
			half();
			sclk_o = 1'b1;
			if (i < 8) rd[i] = line_i;
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_b_o = 1'b1;
		half();
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import adc_ctl_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic power_select_pin_i = 1'b0;
	logic sync_i = 1'b0;
	logic out_ready_i = 1'b1;
	sample_t conv_a_i = '0;
	sample_t conv_b_i = '0;
	logic ser_cs_b_i, ser_clk_i, ser_data_i, host_sdo, ser_data_o, ser_data_oe_o;
	logic in_ready_o, out_valid_o, output_data_clock_o, output_data_clock_oe_o, sample_en_o;
	logic aligner_skip_o, half_delay_active_o, clock_term_on_o;
	out_bus_t out_bus_o;
	ch_state_t chan_a_state_o, chan_b_state_o;
	logic [3:0] out_clock_delay_steps_o, data_delay_steps_o;
	logic [8:0] chan_a_clock_ohms_o, chan_a_data_ohms_o, chan_b_clock_ohms_o, chan_b_data_ohms_o;
	logic [7:0] input_common_level_o;
	logic [31:0] seed = 32'h44A2;
	int err_total = 0;
	int checked = 0;
	logic [7:0] rv [0:8];
	logic [15:0] dflt [0:9] = '{16'h0003, 16'h0100, 16'h0200, 16'h036D, 16'h0400, 16'h0500,
		16'h0600, 16'h0800, 16'h0A14, 16'h0900};
	// ----------------------------------------
	// harness
	// ----------------------------------------
	assign ser_data_i = ser_data_oe_o ? ser_data_o : host_sdo;
	always #20 clk_i = ~clk_i;
	adc_ctl_top DUT (.*);
	adc_host_model host (.clk_i(clk_i), .line_i(ser_data_i), .cs_b_o(ser_cs_b_i),
		.sclk_o(ser_clk_i), .sdo_o(host_sdo));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [9:0] fmt(input logic [9:0] x, input logic [1:0] f, input logic r);
		logic [9:0] y;
		y = (f == 2'h1) ? x : (f == 2'h2) ? (x ^ (x >> 1)) : (x ^ 10'h200);
		x = y;
		for (int i = 0; i < 10; i++) if (r) y[i] = x[9 - i];
		return y;
	endfunction
	function automatic logic [3:0] steps(input logic [2:0] c);
		return (c == 3'h4) ? 4'h0 : c[2] ? -{2'h0, c[1:0]} : {2'h0, c[1:0]};
	endfunction
	function automatic logic [8:0] ohms(input logic [2:0] c);
		return c[2] ? 9'h12C : c[1] ? (c[0] ? 9'h096 : 9'h064) : (c[0] ? 9'h04B : 9'h032);
	endfunction
	function automatic ch_state_t st(input logic [3:0] n, input logic b);
		if (n[3] && n[1:0] != 2'h0) return CH_ACTIVE;
		if (b ? n[1] : n[0]) return CH_ACTIVE;
		return n[2] ? CH_STANDBY : CH_OFF;
	endfunction
	task automatic test_done();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.xfer(1'b0, a, d, x);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		host.xfer(1'b1, a, 8'h00, x);
		chk(x, e);
	endtask
	task automatic defaults();
		for (int i = 0; i < 10; i++) rdchk(dflt[i][14:8], dflt[i][7:0]);
	endtask
	task automatic next_word();
		for (int i = 0; i < 100; i++) begin
			tick(1);
			if (output_data_clock_o === 1'b1) return;
		end
		err_total++;
		test_done();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		logic [9:0] w0, w1;
		int na, nb;
		tick(5);
		rst_b_i = 1'b1;
		tick(10);
		defaults();
		repeat (3) begin
			for (logic [6:0] a = 0; a < 9; a++) begin
				v = rnd();
				if (a == 7'h1) v = v & 8'h1E;
				if (a == 7'h3 && v[5:3] == 3'h4) v[3] = 1'b1;
				if (a == 7'h3 && v[2:0] == 3'h4) v[0] = 1'b1;
				rv[a] = v;
				if (a != 7'h7) wr(a, v);
			end
			for (logic [6:0] a = 0; a < 9; a++) if (a != 7'h7) rdchk(a, rv[a]);
			chk(aligner_skip_o, rv[3][7]);
			chk(half_delay_active_o, rv[3][6] & ~rv[1][1]);
			chk(out_clock_delay_steps_o, steps(rv[3][5:3]));
			chk(data_delay_steps_o, steps(rv[3][2:0]));
			chk({chan_a_clock_ohms_o, chan_a_data_ohms_o}, {ohms(rv[4][5:3]), ohms(rv[4][2:0])});
			chk({chan_b_clock_ohms_o, chan_b_data_ohms_o}, {ohms(rv[5][5:3]), ohms(rv[5][2:0])});
			chk({clock_term_on_o, input_common_level_o}, {rv[6][3], rv[8]});
		end
		for (int n = 0; n < 16; n++) begin
			v = {4'(15 - n), 4'(n)};
			wr(7'h00, v);
			tick(4);
			chk({chan_a_state_o, chan_b_state_o}, {st(v[3:0], 1'b0), st(v[3:0], 1'b1)});
			power_select_pin_i = 1'b1;
			tick(8);
			chk({chan_a_state_o, chan_b_state_o}, {st(v[7:4], 1'b0), st(v[7:4], 1'b1)});
			power_select_pin_i = 1'b0;
			tick(8);
		end
		wr(7'h03, 8'h00);
		wr(7'h0A, 8'hA5);
		rdchk(7'h03, 8'h00);
		wr(7'h0A, 8'h5A);
		defaults();
		for (int k = 0; k < 8; k++) begin
			conv_a_i = 11'(rnd());
			conv_b_i = 11'(rnd());
			wr(7'h06, {2'h0, 2'(k), 4'h0});
			wr(7'h01, {3'h0, ~k[2], k[2], 3'h0});
			next_word();
			chk(out_bus_o.data_a, fmt(conv_a_i.data, 2'(k), k[2]));
			chk(out_bus_o.data_b, fmt(conv_b_i.data, 2'(k), ~k[2]));
		end
		wr(7'h06, 8'h10);
		wr(7'h01, 8'h00);
		wr(7'h00, 8'h09);
		next_word();
		chk(out_bus_o.data_a, ({1'b0, conv_a_i.data} + conv_b_i.data) >> 1);
		wr(7'h00, 8'h03);
		for (int m = 0; m < 2; m++) begin
			wr(7'h01, {5'h0, m[0], 2'h2});
			chk(half_delay_active_o, 1'b0);
			na = 0;
			nb = 0;
			for (int i = 0; i < 8; i++) begin
				tick(1);
				w0 = m[0] ? out_bus_o.data_b : out_bus_o.data_a;
				na += (w0 === conv_a_i.data);
				nb += (w0 === conv_b_i.data);
			end
			chk(na > 0 && nb > 0 && na + nb == 8, 1'b1);
		end
		wr(7'h01, 8'h00);
		wr(7'h06, 8'hD0);
		next_word();
		w0 = out_bus_o.data_a;
		v[0] = out_bus_o.over;
		next_word();
		w1 = out_bus_o.data_a;
		chk({w0 ^ w1, v[0]}, {10'h3FF, w0 == 10'h155});
		chk(out_bus_o.data_b, w1);
		wr(7'h06, 8'h50);
		next_word();
		w0 = out_bus_o.data_a;
		next_word();
		chk(10'(out_bus_o.data_a - w0), 10'h001);
		wr(7'h06, 8'h10);
		wr(7'h00, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(7'h02, {4'h0, 2'(c), 2'h0});
			tick(4);
			chk(out_bus_o.data_a_oe, c[0] ? 10'h3FF : 10'h000);
			if (c[0]) chk(out_bus_o.data_a, c[1] ? 10'h3FF : 10'h000);
		end
		wr(7'h00, 8'h03);
		for (int c = 1; c < 3; c++) begin
			wr(7'h02, 8'(c));
			tick(4);
			chk({output_data_clock_oe_o, out_bus_o.over_oe}, {c != 1, c != 2});
		end
		wr(7'h02, 8'h00);
		for (int d = 0; d < 4; d++) begin
			wr(7'h06, {5'h0, d == 3, 2'(d)});
			na = 0;
			repeat (40) begin
				tick(1);
				na += sample_en_o;
			end
			chk(na, (d == 1) ? 32'h14 : (d == 2) ? 32'h0A : 32'h28);
		end
		out_ready_i = 1'b0;
		for (int i = 0; i < 60 && in_ready_o !== 1'b0; i++) tick(1);
		chk({in_ready_o, out_valid_o}, 2'h1);
		wr(7'h00, 8'h00);
		out_ready_i = 1'b1;
		for (int i = 0; i < 60 && out_valid_o !== 1'b0; i++) tick(1);
		chk(out_valid_o, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
